// [rtl/fault_resp_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FAULT_RESP_REGS_SVH
`define FAULT_RESP_REGS_SVH
`define ADDR_SELF_TEST_STAT 8'h85
`define ADDR_SELF_TEST_CTRL 8'ha0
`define ADDR_SELF_TEST_SIG 8'ha1
`define ADDR_FAULT_FLAGS 8'ha3
`define BIT_SELF_TEST_DONE 4
`define BIT_SELF_TEST_PASS 5
`define BIT_SELF_TEST_GO 0
`define FLAG_VOLTAGE_CHECK 0
`define FLAG_ANGLE_CLAMP 1
`define FLAG_TEMPERATURE 2
`define FLAG_CLIP 3
`define FLAG_SIGPROC_LOGIC 4
`define FLAG_RADIUS_RANGE 5
`define FLAG_POWER_ON 6
`define FLAG_NVM_SINGLEBIT 7
`define FLAG_UNDERVOLTAGE 8
`define FLAG_OVERVOLTAGE 9
`define FLAG_NVM_MULTIBIT 10
`define FLAG_SHADOW_PARITY 11
`define FLAG_OSC_FREQ 12
`define FAULT_FLAGS_RESET 13'h0000
`define SELF_TEST_GOLDEN 32'h6c56c9ef
`define SELF_TEST_TIME_MS 200
`define CLK_CYCLES_PER_MS 100000
`define DRIVE_SEL_HIZ 2'h0
`define DRIVE_SEL_HIGH 2'h1
`define DRIVE_SEL_LOW 2'h2
`endif

// [rtl/fault_resp_pkg.sv]
// types shared by the fault response and self-test logic
package fault_resp_pkg;
   typedef enum logic [1:0] {MODE_ANALOG, MODE_SENT, MODE_PWM} out_mode_e;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} st_state_e;
   typedef struct packed {
      logic hiz;
      logic high;
      logic low;
   } drive_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_s;
   typedef struct packed {
      out_mode_e mode;
      logic digital_fault_hiz_sel;
      logic [1:0] fault_drive_sel;
      logic [1:0] serial_prog_access_sel;
      logic [1:0] fault_hold_sel;
      logic msg_cnt_en;
      logic serial_msg_en;
   } cfg_s;
endpackage

// [rtl/fault_priority.sv]
// ranks the non-critical flags other than NVM single-bit into the half-frequency PWM duty code
`timescale 1ns/1ps
`include "fault_resp_regs.svh"
module fault_priority (
   input wire logic [12:0] flags,
   input wire logic lpf_init,
   output logic [3:0] duty_tenths
);
   import fault_resp_pkg::*;

   // first active flag in rank order wins; 0 means nothing to report
   function automatic logic [3:0] rank_duty(input logic [12:0] f, input logic po);
      logic [3:0] code;
      code = 4'h0;
      if (f[`FLAG_ANGLE_CLAMP]) code = 4'h9;
      if (f[`FLAG_CLIP]) code = 4'h8;
      if (f[`FLAG_OVERVOLTAGE]) code = 4'h7;
      if (f[`FLAG_UNDERVOLTAGE]) code = 4'h6;
      if (f[`FLAG_POWER_ON] || po) code = 4'h5;
      if (f[`FLAG_TEMPERATURE]) code = 4'h4;
      if (f[`FLAG_VOLTAGE_CHECK]) code = 4'h3;
      if (f[`FLAG_RADIUS_RANGE]) code = 4'h2;
      if (f[`FLAG_SIGPROC_LOGIC]) code = 4'h1;
      return code;
   endfunction

   assign duty_tenths = rank_duty(flags, lpf_init);
endmodule

// [rtl/self_test_engine.sv]
// pattern generator, signature compactor and run timer for the logic self-test
`timescale 1ns/1ps
module self_test_engine #(
   parameter int unsigned RUN_CYCLES = 20000000,
   parameter logic [31:0] SEED = 32'h00000001
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic finish,
   output logic [31:0] signature
);
   import fault_resp_pkg::*;

   st_state_e state;
   logic [31:0] lfsr;
   logic [31:0] count;
   logic [31:0] chain_out;

   // stand-in for the scan chain: a fixed nonlinear mix of the pattern
   assign chain_out = (lfsr ^ {lfsr[15:0], lfsr[31:16]}) + {lfsr[7:0], lfsr[31:8]};
   assign busy = (state == ST_RUN);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         count <= 32'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_RUN;
                  count <= 32'h0;
               end
            end
            ST_RUN: begin
               count <= count + 32'h1;
               if (count == RUN_CYCLES - 1) state <= ST_DONE;
            end
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign finish = (state == ST_DONE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr <= 32'h00000001;
         signature <= 32'h0;
      end else if (state == ST_IDLE && start) begin
         lfsr <= SEED;
         signature <= 32'h0;
      end else if (state == ST_RUN) begin
         lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         signature <= {signature[30:0], signature[31] ^ signature[21] ^ signature[1] ^ signature[0]} ^ chain_out;
      end
   end
endmodule

// [rtl/fault_response_and_logic_self_test.sv]
// fault flag register, output fault responses and logic self-test control
// Function
// - self-test runs patterns, compacts, compares checksum
// - self-test takes about 200 ms
// - no register answers while self-test runs
// - done set at end, whatever result
// - pass set only on checksum match
// - computed checksum readable as signature
// - fault_flags bit positions fixed per flag
// - flags ranked by fixed priority order
// - critical flags tri-state digital, drive analog high
// - diag_octet bits map nine flags in order, UV/OV shared
// - PWM halves frequency, duty coded 10..90%
// - hiz select tri-states all flags except undervoltage
// - analog drive per select; power-on, singlebit silent
// - SENT restarts after undervoltage reporting ends
// - upper status bit held frames after undervoltage
// - overvoltage tri-states when access select 0X
// - tri-stated flags never appear in SENT
// - filter initialisation reports like power-on
// - upper status bit ORs four flags
// - PWM sends only highest-priority code
`timescale 1ns/1ps
`include "fault_resp_regs.svh"
module fault_response_and_logic_self_test #(
   parameter int unsigned SELF_TEST_CYCLES = `SELF_TEST_TIME_MS * `CLK_CYCLES_PER_MS,
   parameter logic [31:0] SELF_TEST_EXPECT = `SELF_TEST_GOLDEN
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire fault_resp_pkg::reg_req_s REG_REQ,
   output logic [31:0] REG_RDATA,
   output logic REG_ACK,
   input wire logic UNLOCKED,
   input wire logic [12:0] FAULT_RAW,
   input wire logic LPF_INIT,
   input wire logic FRAME_START,
   input wire fault_resp_pkg::cfg_s CFG,
   output fault_resp_pkg::drive_s OUT_DRIVE,
   output logic [1:0] FRAME_STATUS,
   output logic [7:0] DIAG_OCTET,
   output logic PWM_HALF_FREQ,
   output logic [3:0] PWM_DUTY_TENTHS,
   output logic SENT_RESTART,
   output logic MSG_CNT_CLEAR,
   output logic SERIAL_RESTART,
   output logic SELF_TEST_BUSY
);
   import fault_resp_pkg::*;

   logic [12:0] fault_flags;
   logic [12:0] next_fault_flags;
   logic self_test_done;
   logic self_test_pass;
   logic [31:0] self_test_signature;
   logic st_busy;
   logic st_finish;
   logic st_start;
   logic flags_read;
   logic crit;
   logic ov_hiz;
   logic digital;
   logic lower_any;
   logic other_any;
   logic uv_prev;
   logic [2:0] uv_hold;
   logic report_ok;
   logic [3:0] duty_raw;
   drive_s next_drive;
   logic [7:0] diag_raw;
   logic [1:0] status_raw;

   // writes and reads are simply not answered while the test runs
   assign st_start = REG_REQ.wr && !st_busy && UNLOCKED && REG_REQ.addr == `ADDR_SELF_TEST_CTRL
                     && REG_REQ.wdata[`BIT_SELF_TEST_GO];
   assign flags_read = REG_REQ.rd && !st_busy && REG_REQ.addr == `ADDR_FAULT_FLAGS;
   assign SELF_TEST_BUSY = st_busy;

   self_test_engine #(
      .RUN_CYCLES(SELF_TEST_CYCLES),
      .SEED(32'h00000001)
   ) u_engine (
      .clk(CLK),
      .rst_n(RST_N),
      .start(st_start),
      .busy(st_busy),
      .finish(st_finish),
      .signature(self_test_signature)
   );

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         self_test_done <= 1'b0;
         self_test_pass <= 1'b0;
      end else if (st_start) begin
         self_test_done <= 1'b0;
         self_test_pass <= 1'b0;
      end else if (st_finish) begin
         self_test_done <= 1'b1;
         self_test_pass <= (self_test_signature == SELF_TEST_EXPECT);
      end
   end

   // register port: only mapped offsets answer, never during the test
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_ACK <= 1'b0;
         REG_RDATA <= 32'h0;
      end else begin
         REG_ACK <= 1'b0;
         if ((REG_REQ.rd || REG_REQ.wr) && !st_busy) begin
            case (REG_REQ.addr)
               `ADDR_SELF_TEST_STAT: begin
                  REG_ACK <= 1'b1;
                  REG_RDATA <= 32'h0;
                  REG_RDATA[`BIT_SELF_TEST_DONE] <= self_test_done;
                  REG_RDATA[`BIT_SELF_TEST_PASS] <= self_test_pass;
               end
               `ADDR_SELF_TEST_CTRL: begin
                  REG_ACK <= 1'b1;
                  REG_RDATA <= 32'h0;
               end
               `ADDR_SELF_TEST_SIG: begin
                  REG_ACK <= 1'b1;
                  REG_RDATA <= self_test_signature;
               end
               `ADDR_FAULT_FLAGS: begin
                  REG_ACK <= 1'b1;
                  REG_RDATA <= {19'h0, fault_flags};
               end
               default: REG_ACK <= 1'b0;
            endcase
         end
      end
   end

   // flags stay while the detector holds them; a read or a frame clears the rest
   always_comb begin
      next_fault_flags = fault_flags;
      if (flags_read || FRAME_START) next_fault_flags = 13'h0000;
      next_fault_flags = next_fault_flags | FAULT_RAW;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) fault_flags <= `FAULT_FLAGS_RESET;
      else fault_flags <= next_fault_flags;
   end

   assign digital = (CFG.mode == MODE_SENT) || (CFG.mode == MODE_PWM);
   assign crit = fault_flags[`FLAG_OSC_FREQ] || fault_flags[`FLAG_NVM_MULTIBIT]
                 || fault_flags[`FLAG_SHADOW_PARITY];
   assign ov_hiz = fault_flags[`FLAG_OVERVOLTAGE] && !CFG.serial_prog_access_sel[1];
   assign lower_any = fault_flags[`FLAG_SIGPROC_LOGIC] || fault_flags[`FLAG_RADIUS_RANGE]
                      || fault_flags[`FLAG_VOLTAGE_CHECK] || fault_flags[`FLAG_TEMPERATURE]
                      || fault_flags[`FLAG_UNDERVOLTAGE] || fault_flags[`FLAG_OVERVOLTAGE]
                      || fault_flags[`FLAG_CLIP] || fault_flags[`FLAG_ANGLE_CLAMP];
   // undervoltage keeps its own response under the hiz select
   assign other_any = |(fault_flags & ~(13'h1 << `FLAG_UNDERVOLTAGE)) || LPF_INIT;

   function automatic drive_s sel_drive(input logic [1:0] sel);
      drive_s d;
      d = '0;
      case (sel)
         `DRIVE_SEL_HIGH: d.high = 1'b1;
         `DRIVE_SEL_LOW: d.low = 1'b1;
         default: d.hiz = 1'b1;
      endcase
      return d;
   endfunction

   always_comb begin
      next_drive = '0;
      if (digital) begin
         if (crit || ov_hiz) next_drive.hiz = 1'b1;
         else if (CFG.digital_fault_hiz_sel && other_any) next_drive.hiz = 1'b1;
         else if (fault_flags[`FLAG_UNDERVOLTAGE]) next_drive = sel_drive(CFG.fault_drive_sel);
      end else begin
         if (crit) next_drive.high = 1'b1;
         else if (lower_any) next_drive = sel_drive(CFG.fault_drive_sel);
      end
   end

   assign report_ok = digital && !next_drive.hiz;

   fault_priority u_rank (
      .flags(fault_flags),
      .lpf_init(LPF_INIT),
      .duty_tenths(duty_raw)
   );

   assign diag_raw = {fault_flags[`FLAG_ANGLE_CLAMP], fault_flags[`FLAG_CLIP],
                      fault_flags[`FLAG_UNDERVOLTAGE] || fault_flags[`FLAG_OVERVOLTAGE],
                      fault_flags[`FLAG_POWER_ON] || LPF_INIT, fault_flags[`FLAG_TEMPERATURE],
                      fault_flags[`FLAG_VOLTAGE_CHECK], fault_flags[`FLAG_RADIUS_RANGE],
                      fault_flags[`FLAG_SIGPROC_LOGIC]};
   assign status_raw[0] = fault_flags[`FLAG_SIGPROC_LOGIC] || fault_flags[`FLAG_RADIUS_RANGE]
                          || fault_flags[`FLAG_VOLTAGE_CHECK] || fault_flags[`FLAG_TEMPERATURE]
                          || fault_flags[`FLAG_POWER_ON] || LPF_INIT;
   assign status_raw[1] = fault_flags[`FLAG_UNDERVOLTAGE] || fault_flags[`FLAG_OVERVOLTAGE]
                          || fault_flags[`FLAG_CLIP] || fault_flags[`FLAG_ANGLE_CLAMP]
                          || (uv_hold != 3'h0);

   // undervoltage release: restart SENT and stretch the upper status bit
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         uv_prev <= 1'b0;
         uv_hold <= 3'h0;
         SENT_RESTART <= 1'b0;
         MSG_CNT_CLEAR <= 1'b0;
         SERIAL_RESTART <= 1'b0;
      end else begin
         uv_prev <= fault_flags[`FLAG_UNDERVOLTAGE];
         SENT_RESTART <= 1'b0;
         MSG_CNT_CLEAR <= 1'b0;
         SERIAL_RESTART <= 1'b0;
         if (uv_prev && !fault_flags[`FLAG_UNDERVOLTAGE]) begin
            uv_hold <= {1'b0, CFG.fault_hold_sel} + 3'h1;
            if (CFG.mode == MODE_SENT) begin
               SENT_RESTART <= 1'b1;
               MSG_CNT_CLEAR <= CFG.msg_cnt_en;
               SERIAL_RESTART <= CFG.serial_msg_en;
            end
         end else if (FRAME_START && uv_hold != 3'h0) begin
            uv_hold <= uv_hold - 3'h1;
         end
      end
   end

   // frame status is captured when the next SENT frame is created
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FRAME_STATUS <= 2'h0;
         DIAG_OCTET <= 8'h00;
      end else if (FRAME_START) begin
         if (report_ok && !CFG.digital_fault_hiz_sel) begin
            FRAME_STATUS <= status_raw;
            DIAG_OCTET <= diag_raw;
         end else if (report_ok) begin
            FRAME_STATUS <= {status_raw[1] && (fault_flags[`FLAG_UNDERVOLTAGE] || uv_hold != 3'h0), 1'b0};
            DIAG_OCTET <= {2'b00, fault_flags[`FLAG_UNDERVOLTAGE], 5'h00};
         end else begin
            FRAME_STATUS <= 2'h0;
            DIAG_OCTET <= 8'h00;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         OUT_DRIVE <= '0;
         PWM_HALF_FREQ <= 1'b0;
         PWM_DUTY_TENTHS <= 4'h0;
      end else begin
         OUT_DRIVE <= next_drive;
         // hiz select leaves only undervoltage on the PWM code
         if (CFG.mode == MODE_PWM && report_ok && duty_raw != 4'h0) begin
            PWM_HALF_FREQ <= 1'b1;
            PWM_DUTY_TENTHS <= duty_raw;
         end else begin
            PWM_HALF_FREQ <= 1'b0;
            PWM_DUTY_TENTHS <= 4'h0;
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_test_start;
      st_start;
   endsequence
   sequence s_test_end;
      st_finish ##1 self_test_done;
   endsequence

   a_start_clears_status: assert property (s_test_start |=> !self_test_done && !self_test_pass)
      else $error("start did not clear done and pass");
   a_done_after_run: assert property (s_test_start |=> (!self_test_done throughout st_busy [*8]))
      else $error("done set while test running");
   a_end_sets_done: assert property (st_finish |-> s_test_end)
      else $error("done not set at end of test");
   a_pass_matches_sig: assert property (st_finish |=> self_test_pass == (self_test_signature == SELF_TEST_EXPECT))
      else $error("pass does not follow signature");
   a_silent_busy: assert property (st_busy |=> !REG_ACK)
      else $error("register answered during self-test");
   a_crit_digital_hiz: assert property (crit && digital |=> OUT_DRIVE.hiz && !OUT_DRIVE.high)
      else $error("critical flag did not tri-state output");
   a_crit_analog_high: assert property (crit && CFG.mode == MODE_ANALOG |=> OUT_DRIVE.high)
      else $error("critical flag did not drive analog high");
   a_ov_access_hiz: assert property (digital && ov_hiz |=> OUT_DRIVE.hiz)
      else $error("overvoltage not tri-stated");
   a_hiz_no_report: assert property (FRAME_START && !report_ok |=> FRAME_STATUS == 2'h0 && DIAG_OCTET == 8'h00)
      else $error("tri-stated flag reported in frame");
   a_pwm_top_code: assert property (CFG.mode == MODE_PWM && report_ok && fault_flags[`FLAG_SIGPROC_LOGIC]
                                    |=> PWM_DUTY_TENTHS == 4'h1 && PWM_HALF_FREQ)
      else $error("highest priority PWM code not sent");
   a_singlebit_silent: assert property (fault_flags == (13'h1 << `FLAG_NVM_SINGLEBIT) && !LPF_INIT
                                        && !CFG.digital_fault_hiz_sel |=> OUT_DRIVE == '0 && PWM_DUTY_TENTHS == 4'h0)
      else $error("single-bit fault produced a response");
   a_uv_restart: assert property ($fell(fault_flags[`FLAG_UNDERVOLTAGE]) && CFG.mode == MODE_SENT |=> SENT_RESTART)
      else $error("SENT not restarted after undervoltage");
endmodule

// [verif/frame_host_model.sv]
// host-side model: frames the sensor output and captures status and diagnostics
`timescale 1ns/1ps
module frame_host_model #(
   parameter int PERIOD = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] frame_status,
   input wire logic [7:0] diag_octet,
   input wire fault_resp_pkg::drive_s out_drive,
   output logic frame_start,
   output logic [1:0] last_status,
   output logic [7:0] last_diag,
   output int frames,
   output logic resync
);
   import fault_resp_pkg::*;
   int cnt;
   logic pending;
   initial begin
      frame_start = 1'b0;
      cnt = 0;
   end
   always @(negedge clk) begin
      frame_start <= 1'b0;
      if (run && rst_n) begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         frame_start <= (cnt == 0);
      end
   end
   // capture one edge after the frame request, once the registered status landed
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         frames <= 0;
         last_status <= 2'h0;
         last_diag <= 8'h00;
         resync <= 1'b0;
      end else begin
         pending <= frame_start;
         if (pending) begin
            last_status <= frame_status;
            last_diag <= diag_octet;
            frames <= frames + 1;
            resync <= 1'b0;
         end
         // a high-impedance gap breaks serial message decoding until the next message
         if (out_drive.hiz === 1'b1) resync <= 1'b1;
      end
   end
endmodule

// [verif/fault_response_and_logic_self_test_tb.sv]
// self-checking bench for fault responses and the logic self-test
`timescale 1ns/1ps
`include "fault_resp_regs.svh"
module fault_response_and_logic_self_test_tb;
   import fault_resp_pkg::*;
   localparam int ST_CYC = 20;
   logic clk, rst_n, unlocked, lpf, fs, run, ack, half, restart, mclr, sclr, busy, got;
   reg_req_s req;
   cfg_s cfg;
   drive_s drv;
   logic [12:0] raw;
   logic [31:0] rdata, q, sig0;
   logic [1:0] fstat, lstat, clr_seen;
   logic [7:0] diag, ldiag;
   logic [3:0] duty;
   logic resync;
   int failures, n_checks, seed, cyc, frames, n_rst, n_ack, n;
   fault_response_and_logic_self_test #(.SELF_TEST_CYCLES(ST_CYC)) u_fault_response_and_logic_self_test (
      .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_ACK(ack),
      .UNLOCKED(unlocked), .FAULT_RAW(raw), .LPF_INIT(lpf), .FRAME_START(fs), .CFG(cfg),
      .OUT_DRIVE(drv), .FRAME_STATUS(fstat), .DIAG_OCTET(diag), .PWM_HALF_FREQ(half),
      .PWM_DUTY_TENTHS(duty), .SENT_RESTART(restart), .MSG_CNT_CLEAR(mclr),
      .SERIAL_RESTART(sclr), .SELF_TEST_BUSY(busy));
   frame_host_model u_frame_host_model (
      .clk(clk), .rst_n(rst_n), .run(run), .frame_status(fstat), .diag_octet(diag),
      .out_drive(drv), .frame_start(fs), .last_status(lstat), .last_diag(ldiag),
      .frames(frames), .resync(resync));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (restart === 1'b1) begin
         n_rst <= n_rst + 1;
         clr_seen <= {mclr, sclr};
      end
      if (ack === 1'b1) n_ack <= n_ack + 1;
      if (cyc == 30000) begin
         failures = failures + 1;
         results();
      end
   end
   task results();
      $display("failures=%0d checks=%0d", failures, n_checks);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what = "value");
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task settle(input int c);
      repeat (c) @(negedge clk);
   endtask
   // one-cycle request, then watch a few cycles for the answer
   task reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
      got = 1'b0;
      q = 32'h0;
      @(negedge clk);
      req = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge clk);
      req.wr = 1'b0;
      req.rd = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (!got && ack === 1'b1) begin
            got = 1'b1;
            q = rdata;
         end
         @(negedge clk);
      end
   endtask
   task clear_flags();
      raw = 13'h0;
      lpf = 1'b0;
      settle(2);
      reg_op(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
   endtask
   task wait_frames(input int k);
      int f0;
      f0 = frames;
      for (int i = 0; i < k * 20 && frames < f0 + k; i++) @(negedge clk);
   endtask
   function automatic logic [3:0] exp_duty(logic [12:0] f, logic l);
      int order [9] = '{4, 5, 0, 2, 6, 8, 9, 3, 1};
      logic [12:0] g;
      g = f | (13'(l) << 6);
      for (int i = 0; i < 9; i++) if (g[order[i]]) return 4'(i + 1);
      return 4'h0;
   endfunction
   function automatic logic [7:0] exp_diag(logic [12:0] f, logic l, logic h);
      // any flag besides undervoltage tri-states the output, so nothing is framed
      if (h && (((f & 13'h1eff) != 13'h0) || l)) return 8'h00;
      if (h) return {2'b00, f[8], 5'b00000};
      return {f[1], f[3], f[8] | f[9], f[6] | l, f[2], f[0], f[5], f[4]};
   endfunction
   function automatic logic [1:0] exp_stat(logic [12:0] f, logic l, logic h);
      if (h && (((f & 13'h1eff) != 13'h0) || l)) return 2'h0;
      if (h) return {f[8], 1'b0};
      return {f[8] | f[9] | f[3] | f[1], f[4] | f[5] | f[0] | f[2] | f[6] | l};
   endfunction
   initial begin
      seed = 95822;
      failures = 0;
      n_checks = 0;
      cyc = 0;
      n_rst = 0;
      n_ack = 0;
      rst_n = 1'b0;
      unlocked = 1'b0;
      lpf = 1'b0;
      run = 1'b0;
      raw = 13'h0;
      req = '0;
      cfg = '{mode: MODE_PWM, digital_fault_hiz_sel: 1'b0, fault_drive_sel: `DRIVE_SEL_HIGH,
              serial_prog_access_sel: 2'b10, fault_hold_sel: 2'h0, msg_cnt_en: 1'b1, serial_msg_en: 1'b1};
      settle(5);
      rst_n = 1'b1;
      reg_op(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
      check(q, 32'(`FAULT_FLAGS_RESET));
      reg_op(1'b0, 8'h10, 32'h0);
      check(32'(got), 32'h0);
      for (int i = 0; i < 13; i++) begin
         raw = 13'h1 << i;
         settle(3);
         raw = 13'h0;
         reg_op(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
         check(q, 32'h1 << i);
      end
      for (int k = 0; k < 50; k++) begin
         raw = (k < 10) ? 13'h1 << k : 13'($random(seed)) & 13'h03ff;
         lpf = (k >= 10) && (($random(seed) & 3) == 0);
         settle(4);
         check(32'(duty), 32'(exp_duty(raw, lpf)));
         check(32'(half), 32'(exp_duty(raw, lpf) != 4'h0));
         clear_flags();
      end
      for (int c = 10; c < 13; c++) begin
         raw = (13'h1 << c) | (13'($random(seed)) & 13'h03ff);
         cfg.digital_fault_hiz_sel = c[0];
         settle(4);
         check(32'(drv.hiz), 32'h1);
         cfg.mode = MODE_ANALOG;
         settle(3);
         check(32'(drv), 32'(3'b010));
         cfg.mode = MODE_PWM;
         clear_flags();
      end
      cfg.digital_fault_hiz_sel = 1'b0;
      for (int s = 0; s < 3; s++) begin
         cfg.serial_prog_access_sel = 2'(s);
         raw = 13'h1 << `FLAG_OVERVOLTAGE;
         settle(4);
         check(32'(drv.hiz), 32'(s < 2));
         clear_flags();
      end
      cfg.serial_prog_access_sel = 2'b10;
      cfg.mode = MODE_ANALOG;
      for (int k = 0; k < 20; k++) begin
         raw = (k < 2) ? 13'h1 << (6 + k) : 13'($random(seed)) & 13'h03ff;
         cfg.fault_drive_sel = 2'(k % 3);
         settle(4);
         check(32'(drv), (raw & 13'h033f) == 13'h0 ? 32'h0 : 32'h4 >> (k % 3));
         clear_flags();
      end
      cfg.mode = MODE_SENT;
      run = 1'b1;
      for (int k = 0; k < 30; k++) begin
         raw = 13'($random(seed)) & 13'h03ff;
         lpf = ($random(seed) & 3) == 0;
         cfg.digital_fault_hiz_sel = (k >= 15);
         wait_frames(3);
         check(32'(ldiag), 32'(exp_diag(raw, lpf, k >= 15)));
         check(32'(lstat), 32'(exp_stat(raw, lpf, k >= 15)));
         if (k >= 15 && (raw & 13'h1eff) != 13'h0) begin
            check(32'(drv.hiz), 32'h1);
            check(32'(resync), 32'h1);
         end
      end
      cfg.digital_fault_hiz_sel = 1'b0;
      for (int h = 0; h < 4; h++) begin
         raw = 13'h1 << `FLAG_UNDERVOLTAGE;
         lpf = 1'b0;
         cfg.fault_hold_sel = 2'(h);
         cfg.msg_cnt_en = $random(seed);
         cfg.serial_msg_en = $random(seed);
         run = 1'b1;
         wait_frames(2);
         run = 1'b0;
         raw = 13'h0;
         settle(10);
         n = n_rst;
         reg_op(1'b0, `ADDR_FAULT_FLAGS, 32'h0);
         check(32'(n_rst - n), 32'h1);
         check(32'(clr_seen), 32'({cfg.msg_cnt_en, cfg.serial_msg_en}));
         run = 1'b1;
         for (int f = 0; f < h + 2; f++) begin
            wait_frames(1);
            check(32'(lstat[1]), 32'(f <= h));
         end
      end
      check({mclr, sclr}, 2'b00);
      run = 1'b0;
      reg_op(1'b1, `ADDR_SELF_TEST_CTRL, 32'h1);
      check(32'(busy), 32'h0);
      unlocked = 1'b1;
      reg_op(1'b1, `ADDR_SELF_TEST_CTRL, 32'h0);
      check(32'(busy), 32'h0);
      for (int r = 0; r < 2; r++) begin
         reg_op(1'b1, `ADDR_SELF_TEST_CTRL, 32'h1);
         n = n_ack;
         for (int c = 0; c < 3 && busy === 1'b1; c++) begin
            req.rd = (c == 0);
            req.addr = `ADDR_SELF_TEST_STAT;
            @(negedge clk);
         end
         req.rd = 1'b0;
         while (busy === 1'b1 && n_ack < 1000) @(negedge clk);
         check(32'(n_ack - n), 32'h0);
         reg_op(1'b0, `ADDR_SELF_TEST_SIG, 32'h0);
         if (r == 0) sig0 = q;
         else check(q, sig0);
         reg_op(1'b0, `ADDR_SELF_TEST_STAT, 32'h0);
         check(32'(q[`BIT_SELF_TEST_DONE]), 32'h1);
         check(32'(q[`BIT_SELF_TEST_PASS]), 32'(sig0 === `SELF_TEST_GOLDEN));
      end
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: `ADDR_SELF_TEST_CTRL, wdata: 32'h1};
      @(negedge clk);
      req.wr = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         n = n + 1;
         @(negedge clk);
      end
      check(32'(n), 32'(ST_CYC));
      reg_op(1'b0, `ADDR_SELF_TEST_CTRL, 32'h0);
      check(q, 32'h0);
      results();
   end
endmodule
